// ==== tb/cpci_assertions.sv ====
/* Checker on cpci_top ports: strobes, bit timing, requests, modes.
   Assumes it is bound into cpci_top. */
`timescale 1ns/1ps
`default_nettype none
`include "cpci_regs.svh"

module cpci_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Observed
    input wire logic txd,
    input wire logic cmd_valid,
    input wire logic [6:0] cmd_num,
    input wire logic [5:0] cmd_len,
    input wire logic [`CPCI_FIELD_W-1:0] cmd_chars,
    // Message source
    input wire logic msg_req,
    input wire logic [6:0] msg_req_num,
    input wire logic st_valid,
    input wire logic st_last,
    input wire logic st_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // Mode shadow
    logic poll, evo, armed, outst;
    logic [15:0] low_run;
    wire [7:0] dig = cmd_chars[7:0];
    wire comma = cmd_chars[15:8] == 8'h2C;
    wire m12 = cmd_valid && cmd_num == 7'h0C && comma;
    wire m17 = cmd_valid && cmd_num == 7'h11 && comma;
    wire next_poll = m17 ? dig == 8'h31 || dig == 8'h32 ||
        dig != 8'h30 && poll : poll;
    wire next_evo = m12 ? dig == 8'h31 || dig != 8'h30 && evo : evo;
    wire next_armed = next_poll && (armed && !msg_req ||
        cmd_valid && cmd_num == 7'h0D && poll);
    wire next_outst = msg_req || outst && !(st_valid && st_ready && st_last);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {poll, evo, armed, outst} <= 4'h0;
            low_run <= 16'h0000;
        end else begin
            {poll, evo, armed, outst} <=
                {next_poll, next_evo, next_armed, next_outst};
            low_run <= txd ? 16'h0000 : low_run + 16'h0001;
        end
    end
    function automatic logic [5:0] max_len(input logic [6:0] n);
        case (n)
            7'h05, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0C, 7'h0E, 7'h0F,
            7'h10, 7'h11, 7'h17, 7'h18: max_len = 6'h05;
            7'h06: max_len = 6'h0A;
            7'h0B: max_len = 6'h27;
            7'h0D: max_len = 6'h06;
            7'h13: max_len = 6'h1F;
            7'h15: max_len = 6'h28;
            7'h16: max_len = 6'h07;
            default: max_len = 6'h00;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////
    sequence s_first_req;
        msg_req && msg_req_num == 7'h33;
    endsequence
    sequence s_char_end;
        $rose(txd);
    endsequence
    a_cmd_strobe: assert property (cmd_valid |=> !cmd_valid)
        else $error("cmd_valid too long");
    a_cmd_legal: assert property (cmd_valid |->
        cmd_len >= 6'h03 && cmd_len <= max_len(cmd_num))
        else $error("bad frame accepted");
    a_req_strobe: assert property (msg_req |=> !msg_req)
        else $error("msg_req too long");
    a_first_req: assert property ($fell(sys_rst) |-> ##[1:3] s_first_req)
        else $error("no first request");
    a_txd_reset: assert property (disable iff (1'b0)
        sys_rst |=> txd) else $error("txd not idle");
    a_bit_time: assert property (s_char_end |->
        low_run % 16'h0A2C == 16'h0000)
        else $error("txd low not whole bits");
    a_req_single: assert property (msg_req |-> !outst)
        else $error("request overlap");
    // Stream state opens at the edge that raises msg_req
    a_ready_owned: assert property (st_ready |-> outst || msg_req)
        else $error("stray st_ready");
    a_poll_quiet: assert property (
        msg_req && poll && $past(poll) && !cmd_valid |-> armed)
        else $error("unpolled request");
    a_event_only: assert property (
        msg_req && evo && $past(evo) && !poll |-> msg_req_num == 7'h3E)
        else $error("non-event request");
endmodule // cpci_assertions

bind cpci_top cpci_assertions chk (.*);
`default_nettype wire

// ==== tb/cpci_bench.sv ====
/* Bench for cpci_top: registers, modes, acks, requests, drops.
   Assumes host model and checker compiled with it. */
`timescale 1ns/1ps
`default_nettype none
`include "cpci_regs.svh"

module cpci_bench;
    localparam int CHAR = 32'h0000_65B8;
    localparam int LIMIT = 32'h007A_1200;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rxd, txd, cmd_valid, msg_req, st_ready;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wstb = 1'b0;
    logic reg_rstb = 1'b0;
    logic [31:0] reg_rdata;
    logic [6:0] cmd_num, msg_req_num;
    logic [5:0] cmd_len;
    logic [`CPCI_FIELD_W-1:0] cmd_chars;
    logic event_pending = 1'b0;
    logic st_valid = 1'b0;
    logic [7:0] st_data = 8'h0A;
    logic st_last = 1'b1;
    logic [6:0] req_q[$];
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int cmd_cnt = 0;
    int exp_ack = 0;
    int exp_cmd = 0;
    int src_wait = 0;

    cpci_top DUT (.*);
    cpci_host_model host (.clk(clk), .rxd(rxd), .txd(txd));

    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////
    // Source: one LF per request
    always @(posedge clk) begin
        cycles++;
        if (cmd_valid === 1'b1) cmd_cnt++;
        if (msg_req === 1'b1) begin
            req_q.push_back(msg_req_num);
            src_wait <= 6;
        end else if (src_wait > 0) begin
            src_wait <= src_wait - 1;
            if (src_wait == 1) begin
                st_valid <= 1'b1;
                st_data <= 8'h0A;
            end
        end
        if (st_valid && st_ready) begin
            st_valid <= 1'b0;
            st_data <= ~st_data;
        end
        if (cycles == LIMIT) begin
            fail_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wstb <= 1'b1;
        @(posedge clk);
        reg_wstb <= 1'b0;
    endtask
    task automatic reg_rd(input string n, input logic [7:0] a,
            input logic [31:0] m, input logic [31:0] e);
        reg_addr <= a;
        reg_rstb <= 1'b1;
        @(posedge clk);
        reg_rstb <= 1'b0;
        @(negedge clk);
        check(n, reg_rdata & m, e);
        @(posedge clk);
    endtask
    task automatic frame(input string s, input int a, input int c);
        exp_ack += a;
        exp_cmd += c;
        host.send(s, 1'b1);
        for (int i = 0; i < 10 * CHAR; i++) begin
            if (a == 1 && host.ack_count == exp_ack) break;
            @(posedge clk);
        end
        check({s, " acks"}, host.ack_count, exp_ack);
        check({s, " cmds"}, cmd_cnt, exp_cmd);
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        reg_rd("cfg reset", 8'h00, 32'hFFFF_FFFF, 32'h0000_3E33);
        reg_wr(8'h00, 32'h0000_3433);
        reg_rd("cfg", 8'h00, 32'hFFFF_FFFF, 32'h0000_3433);
        reg_wr(8'h04, 32'hFFFF_FFFF);
        reg_rd("stat ro", 8'h04, 32'h0000_7F07, 32'h0000_0000);
        reg_rd("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        for (int i = 0; i < 5 * CHAR && req_q.size() < 3; i++)
            @(posedge clk);
        for (int i = 0; i < 3; i++)
            check("bcast req", req_q[i], (i == 1) ? 32'h34 : 32'h33);
        frame("#12,1", 1, 1);
        check("num", cmd_num, 32'h0000_000C);
        check("len", cmd_len, 32'h0000_0005);
        check("chars", cmd_chars[15:0], 32'h0000_2C31);
        reg_rd("stat", 8'h04, 32'h0000_7F07, 32'h0000_0C01);
        req_q.delete();
        repeat (3 * CHAR) @(posedge clk);
        check("evo quiet", req_q.size(), 0);
        event_pending <= 1'b1;
        repeat (3 * CHAR) @(posedge clk);
        event_pending <= 1'b0;
        check("evo reqs", req_q.size() > 0, 1);
        foreach (req_q[i]) check("evo num", req_q[i], 32'h3E);
        frame("#12,0", 1, 1);
        frame("#17,1", 1, 1);
        reg_rd("stat", 8'h04, 32'h0000_7F07, 32'h0000_1102);
        req_q.delete();
        repeat (3 * CHAR) @(posedge clk);
        check("poll quiet", req_q.size(), 0);
        frame("#13,51", 1, 1);
        repeat (3 * CHAR) @(posedge clk);
        check("poll num", req_q[0], 32'h33);
        frame("#17,2", 1, 1);
        req_q.delete();
        frame("#13,52", 0, 1);
        repeat (3 * CHAR) @(posedge clk);
        check("mute num", req_q[0], 32'h34);
        frame("#12,9", 0, 1);
        reg_rd("stat", 8'h04, 32'h0000_7F07, 32'h0000_0C04);
        frame("#17,0", 0, 1);
        reg_rd("stat", 8'h04, 32'h0000_7F07, 32'h0000_1100);
        frame("#99,1", 0, 0);
        frame("#12,11", 0, 0);
        reg_rd("drop", 8'h0C, 32'h0000_FFFF, 32'h0000_0002);
        reg_rd("acc", 8'h08, 32'h0000_FFFF, exp_cmd);
        host.send("#12,1", 1'b0);
        repeat (3 * CHAR) @(posedge clk);
        check("no terminator", cmd_cnt, exp_cmd);
        frame("", 1, 1);
        check("stop bits", host.bad_stop, 0);
        wrap_up();
    end
endmodule // cpci_bench
`default_nettype wire

// ==== tb/cpci_host_model.sv ====
/* Host model: sends frames on rxd, counts acks on txd.
   Assumes 2604 device clocks a bit. */
`timescale 1ns/1ps
`default_nettype none

module cpci_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic rxd,
    input wire logic txd
);
    localparam int BIT = 32'h0000_0A2C;
    localparam logic [55:0] ACK = {"#50,1", 8'h0D, 8'h0A};
    logic [55:0] hist = 56'h0;
    logic [7:0] c = 8'h00;
    int ack_count = 0;
    int bad_stop = 0;
    initial rxd = 1'b1;
    ////////////////////////////////////////////////////////////
    task automatic send_char(input logic [7:0] ch);
        rxd <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rxd <= ch[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    // Caller pads fields
    task automatic send(input string s, input bit term);
        for (int i = 0; i < s.len(); i++) send_char(s[i]);
        if (term) begin
            send_char(8'h0D);
            send_char(8'h0A);
        end
    endtask
    // Listen only
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            c = {txd, c[7:1]};
        end
        repeat (BIT) @(posedge clk);
        if (txd !== 1'b1) bad_stop++;
        hist = {hist[47:0], c};
        if (hist == ACK) ack_count++;
    end
endmodule // cpci_host_model
`default_nettype wire

// ==== verilog/cpci_pkg.sv ====
/*
 * Types of the control-port command interpreter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpci_pkg;
    typedef enum {OUT_ALL, OUT_EVENT_ONLY} cpci_out_t;
    typedef enum {COM_BCAST, COM_POLL_ACK, COM_POLL_MUTE} cpci_com_t;
    typedef enum {P_HUNT, P_NUM_HI, P_NUM_LO, P_BODY, P_LF, P_SKIP}
        cpci_parse_t;
    typedef enum {T_IDLE, T_ACK, T_STREAM} cpci_tx_t;
    typedef enum {U_IDLE, U_START, U_DATA, U_STOP} cpci_urx_t;
endpackage

// ==== verilog/cpci_regs.svh ====
/*
 * Constants of the control-port command interpreter: serial timing,
 * character codes, message numbers, frame lengths, register map.
 * Assumes inclusion by bare name from every design file but the package.
 */
`ifndef CPCI_REGS_SVH
`define CPCI_REGS_SVH

// Serial timing
`define CPCI_CLK_HZ 25000000
`define CPCI_BAUD 9600
`define CPCI_BIT_CYC (`CPCI_CLK_HZ / `CPCI_BAUD)
`define CPCI_HALF_CYC (`CPCI_BIT_CYC / 2)
`define CPCI_TX_BITS 4'h9

// Character codes
`define CPCI_CH_HASH 8'h23
`define CPCI_CH_CR 8'h0D
`define CPCI_CH_LF 8'h0A
`define CPCI_CH_COMMA 8'h2C
`define CPCI_CH_ZERO 8'h30
`define CPCI_CH_ONE 8'h31
`define CPCI_CH_TWO 8'h32
`define CPCI_CH_FIVE 8'h35
`define CPCI_CH_NINE 8'h39

// Message numbers, decimal base, last acknowledge character index
`define CPCI_MSG_OUTSEL 7'h0C
`define CPCI_MSG_REQ 7'h0D
`define CPCI_MSG_POLL 7'h11
`define CPCI_MSG_EVENT 7'h3E
`define CPCI_DEC 7'h0A
`define CPCI_ACK_LAST 3'h6

// Frame lengths, hash and number included, terminator excluded
`define CPCI_LEN_DIGIT 6'h05
`define CPCI_LEN_BIAS 6'h0A
`define CPCI_LEN_POPOLD 6'h27
`define CPCI_LEN_REQ 6'h06
`define CPCI_LEN_POS 6'h1F
`define CPCI_LEN_POP 6'h28
`define CPCI_LEN_EVT 6'h07
`define CPCI_LEN_NUM 6'h03
`define CPCI_FIELD_W 320

// Register map, byte addresses
`define CPCI_REG_CFG 8'h00
`define CPCI_REG_STAT 8'h04
`define CPCI_REG_ACC 8'h08
`define CPCI_REG_DROP 8'h0C
`define CPCI_CFG_RST 32'h0000_3E33

`endif

// ==== verilog/cpci_top.sv ====
/*
 * Control-port command interpreter: frame parser, output mode state,
 * acknowledge generator, status message scheduling, register port.
 * Assumes a message source that answers every msg_req with one
 * complete frame on the st_* stream, ending with st_last.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpci_regs.svh"

module cpci_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control port serial pins
    input wire logic rxd,
    output logic txd,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wstb,
    input wire logic reg_rstb,
    output logic [31:0] reg_rdata,
    // Accepted commands to function units
    output logic cmd_valid,
    output logic [6:0] cmd_num,
    output logic [5:0] cmd_len,
    output logic [`CPCI_FIELD_W-1:0] cmd_chars,
    // Status message source
    input wire logic event_pending,
    output logic msg_req,
    output logic [6:0] msg_req_num,
    input wire logic st_valid,
    input wire logic [7:0] st_data,
    input wire logic st_last,
    output logic st_ready
);
    ////////////////////////////////////////////////////////////////////
    // Serial ends
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;

    cpci_uart_rx u_rx (
        .clk(clk),
        .sys_rst(sys_rst),
        .rxd(rxd),
        .rx_valid(rx_valid),
        .rx_data(rx_data)
    );

    cpci_uart_tx u_tx (
        .clk(clk),
        .sys_rst(sys_rst),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready),
        .txd(txd)
    );

    ////////////////////////////////////////////////////////////////////
    // Frame parser
    function automatic logic [5:0] max_len(input logic [6:0] n);
        unique case (n)
            7'h05, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0C, 7'h0E, 7'h0F,
            7'h10, 7'h11, 7'h17, 7'h18: max_len = `CPCI_LEN_DIGIT;
            7'h06: max_len = `CPCI_LEN_BIAS;
            7'h0B: max_len = `CPCI_LEN_POPOLD;
            7'h0D: max_len = `CPCI_LEN_REQ;
            7'h13: max_len = `CPCI_LEN_POS;
            7'h15: max_len = `CPCI_LEN_POP;
            7'h16: max_len = `CPCI_LEN_EVT;
            default: max_len = 6'h00;
        endcase
    endfunction

    cpci_pkg::cpci_parse_t pstate;
    cpci_pkg::cpci_out_t out_mode;
    cpci_pkg::cpci_com_t com_mode;
    logic [3:0] num_hi;
    logic [6:0] num;
    logic [5:0] len;
    logic [`CPCI_FIELD_W-1:0] field;
    logic [15:0] acc_cnt;
    logic [15:0] drop_cnt;
    logic ack_pend;
    logic poll_pend;
    logic [6:0] poll_num;

    wire is_digit = rx_data >= `CPCI_CH_ZERO && rx_data <= `CPCI_CH_NINE;
    wire [3:0] digit = 4'(rx_data - `CPCI_CH_ZERO);
    wire [6:0] num_next = 7'({3'h0, num_hi} * `CPCI_DEC) + {3'h0, digit};
    wire [5:0] lim = max_len(num);
    wire is_lf = rx_data == `CPCI_CH_LF;
    wire body_full = len >= lim;
    wire frame_ok = rx_valid && pstate == cpci_pkg::P_LF && is_lf;
    wire frame_bad = rx_valid && (
        (pstate == cpci_pkg::P_NUM_HI && !is_digit) ||
        (pstate == cpci_pkg::P_NUM_LO && (!is_digit ||
            max_len(num_next) == 6'h00)) ||
        (pstate == cpci_pkg::P_BODY && !is_lf && body_full &&
            rx_data != `CPCI_CH_CR) ||
        (pstate == cpci_pkg::P_BODY && is_lf) ||
        (pstate == cpci_pkg::P_LF && !is_lf));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pstate <= cpci_pkg::P_HUNT;
            num_hi <= 4'h0;
            num <= 7'h00;
            len <= 6'h00;
            field <= '0;
        end else if (rx_valid) begin
            unique case (pstate)
                cpci_pkg::P_HUNT: if (rx_data == `CPCI_CH_HASH) begin
                    pstate <= cpci_pkg::P_NUM_HI;
                    field <= '0;
                end
                cpci_pkg::P_NUM_HI: begin
                    num_hi <= digit;
                    pstate <= is_digit ? cpci_pkg::P_NUM_LO
                                       : cpci_pkg::P_SKIP;
                end
                cpci_pkg::P_NUM_LO: begin
                    num <= num_next;
                    len <= `CPCI_LEN_NUM;
                    pstate <= frame_bad ? cpci_pkg::P_SKIP
                                        : cpci_pkg::P_BODY;
                end
                cpci_pkg::P_BODY: begin
                    if (rx_data == `CPCI_CH_CR) begin
                        pstate <= cpci_pkg::P_LF;
                    end else if (frame_bad) begin
                        // Line feed without CR ends the frame here
                        pstate <= is_lf ? cpci_pkg::P_HUNT
                                        : cpci_pkg::P_SKIP;
                    end else begin
                        field <= {field[`CPCI_FIELD_W-9:0], rx_data};
                        len <= len + 6'h01;
                    end
                end
                cpci_pkg::P_LF: begin
                    pstate <= is_lf ? cpci_pkg::P_HUNT
                                    : cpci_pkg::P_SKIP;
                end
                cpci_pkg::P_SKIP: if (is_lf) begin
                    pstate <= cpci_pkg::P_HUNT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command effects
    wire [7:0] last_ch = field[7:0];
    wire [7:0] prev_ch = field[15:8];
    wire one_digit = len == `CPCI_LEN_DIGIT && prev_ch == `CPCI_CH_COMMA;
    wire is_outsel = frame_ok && num == `CPCI_MSG_OUTSEL && one_digit;
    wire is_comsel = frame_ok && num == `CPCI_MSG_POLL && one_digit;
    wire [3:0] req_hi = 4'(prev_ch - `CPCI_CH_ZERO);
    wire [3:0] req_lo = 4'(last_ch - `CPCI_CH_ZERO);
    wire req_digits = prev_ch >= `CPCI_CH_ZERO &&
        prev_ch <= `CPCI_CH_NINE && last_ch >= `CPCI_CH_ZERO &&
        last_ch <= `CPCI_CH_NINE;
    wire polling = com_mode != cpci_pkg::COM_BCAST;
    wire is_req = frame_ok && num == `CPCI_MSG_REQ && polling &&
        len == `CPCI_LEN_REQ && req_digits;
    wire ack_set = frame_ok && com_mode != cpci_pkg::COM_POLL_MUTE;

    logic ack_clr;
    logic poll_clr;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_mode <= cpci_pkg::OUT_ALL;
            com_mode <= cpci_pkg::COM_BCAST;
            ack_pend <= 1'b0;
            poll_pend <= 1'b0;
            poll_num <= 7'h00;
            cmd_valid <= 1'b0;
            cmd_num <= 7'h00;
            cmd_len <= 6'h00;
            cmd_chars <= '0;
            acc_cnt <= 16'h0000;
            drop_cnt <= 16'h0000;
        end else begin
            cmd_valid <= frame_ok;
            if (frame_ok) begin
                cmd_num <= num;
                cmd_len <= len;
                cmd_chars <= field;
                acc_cnt <= acc_cnt + 16'h0001;
            end
            if (frame_bad) begin
                drop_cnt <= drop_cnt + 16'h0001;
            end
            // Unknown digits leave the mode as it was
            if (is_outsel && last_ch == `CPCI_CH_ZERO) begin
                out_mode <= cpci_pkg::OUT_ALL;
            end else if (is_outsel && last_ch == `CPCI_CH_ONE) begin
                out_mode <= cpci_pkg::OUT_EVENT_ONLY;
            end
            if (is_comsel && last_ch == `CPCI_CH_ZERO) begin
                com_mode <= cpci_pkg::COM_BCAST;
            end else if (is_comsel && last_ch == `CPCI_CH_ONE) begin
                com_mode <= cpci_pkg::COM_POLL_ACK;
            end else if (is_comsel && last_ch == `CPCI_CH_TWO) begin
                com_mode <= cpci_pkg::COM_POLL_MUTE;
            end
            // Set wins over clear in the same cycle
            if (ack_set) begin
                ack_pend <= 1'b1;
            end else if (ack_clr) begin
                ack_pend <= 1'b0;
            end
            if (is_req) begin
                poll_pend <= 1'b1;
                poll_num <= 7'({3'h0, req_hi} * `CPCI_DEC) + {3'h0, req_lo};
            end else if (poll_clr || !polling) begin
                poll_pend <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register port
    logic [31:0] cfg;
    wire [6:0] bc_first = cfg[6:0];
    wire [6:0] bc_last = cfg[14:8];
    wire sel_cfg = reg_addr == `CPCI_REG_CFG;
    wire sel_stat = reg_addr == `CPCI_REG_STAT;
    wire sel_acc = reg_addr == `CPCI_REG_ACC;
    wire sel_drop = reg_addr == `CPCI_REG_DROP;
    wire [1:0] com_code = com_mode == cpci_pkg::COM_POLL_ACK ? 2'h1 :
        com_mode == cpci_pkg::COM_POLL_MUTE ? 2'h2 : 2'h0;
    wire [31:0] stat = {17'h0_0000, cmd_num, 2'h0,
        pstate != cpci_pkg::P_HUNT, poll_pend, ack_pend, com_code,
        out_mode == cpci_pkg::OUT_EVENT_ONLY};
    wire [31:0] rd_mux = sel_cfg ? {17'h0_0000, cfg[14:8], 1'b0, cfg[6:0]}
        : sel_stat ? stat : sel_acc ? {16'h0000, acc_cnt}
        : sel_drop ? {16'h0000, drop_cnt} : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg <= `CPCI_CFG_RST;
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (reg_wstb && sel_cfg) begin
                cfg <= reg_wdata;
            end
            reg_rdata <= reg_rstb ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit scheduling; acknowledges go first
    cpci_pkg::cpci_tx_t tstate;
    logic [2:0] ack_idx;
    logic [6:0] bc_num;
    logic [7:0] ack_ch;

    always_comb begin
        unique case (ack_idx)
            3'h0: ack_ch = `CPCI_CH_HASH;
            3'h1: ack_ch = `CPCI_CH_FIVE;
            3'h2: ack_ch = `CPCI_CH_ZERO;
            3'h3: ack_ch = `CPCI_CH_COMMA;
            3'h4: ack_ch = `CPCI_CH_ONE;
            3'h5: ack_ch = `CPCI_CH_CR;
            default: ack_ch = `CPCI_CH_LF;
        endcase
    end

    wire bcast_all = !polling && out_mode == cpci_pkg::OUT_ALL;
    wire want_msg = polling ? poll_pend
        : out_mode == cpci_pkg::OUT_ALL ? 1'b1
        : event_pending;
    wire [6:0] want_num = polling ? poll_num
        : out_mode == cpci_pkg::OUT_ALL ? bc_num : `CPCI_MSG_EVENT;
    wire in_ack = tstate == cpci_pkg::T_ACK;
    wire in_stream = tstate == cpci_pkg::T_STREAM;
    wire launch_msg = tstate == cpci_pkg::T_IDLE && !ack_pend && want_msg;

    assign ack_clr = tstate == cpci_pkg::T_IDLE && ack_pend;
    assign poll_clr = launch_msg && polling;
    assign tx_valid = in_ack || (in_stream && st_valid);
    assign tx_data = in_ack ? ack_ch : st_data;
    assign st_ready = in_stream && tx_ready;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tstate <= cpci_pkg::T_IDLE;
            ack_idx <= 3'h0;
            bc_num <= bc_first;
            msg_req <= 1'b0;
            msg_req_num <= 7'h00;
        end else begin
            msg_req <= launch_msg;
            unique case (tstate)
                cpci_pkg::T_IDLE: begin
                    ack_idx <= 3'h0;
                    if (ack_pend) begin
                        tstate <= cpci_pkg::T_ACK;
                    end else if (want_msg) begin
                        msg_req_num <= want_num;
                        tstate <= cpci_pkg::T_STREAM;
                    end
                end
                cpci_pkg::T_ACK: if (tx_ready) begin
                    ack_idx <= ack_idx + 3'h1;
                    if (ack_idx == `CPCI_ACK_LAST) begin
                        tstate <= cpci_pkg::T_IDLE;
                    end
                end
                cpci_pkg::T_STREAM: if (st_valid && tx_ready && st_last) begin
                    // Nothing awaited from the host after a frame
                    tstate <= cpci_pkg::T_IDLE;
                    if (bcast_all) begin
                        bc_num <= bc_num >= bc_last ? bc_first
                                                    : bc_num + 7'h01;
                    end
                end
            endcase
        end
    end
endmodule // cpci_top
`default_nettype wire

// ==== verilog/cpci_uart_rx.sv ====
/*
 * Serial receiver, 8 data bits, no parity, one stop bit.
 * Assumes rxd is asynchronous; it is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpci_regs.svh"

module cpci_uart_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial line
    input wire logic rxd,
    // Received characters
    output logic rx_valid,
    output logic [7:0] rx_data
);
    logic sync1;
    logic sync2;
    logic [11:0] cnt;
    logic [2:0] bitn;
    cpci_pkg::cpci_urx_t state;
    wire cnt_done = (cnt == 12'h000);

    always_ff @(posedge clk) begin
        sync1 <= rxd;
        sync2 <= sync1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= cpci_pkg::U_IDLE;
            cnt <= 12'h000;
            bitn <= 3'h0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            cnt <= cnt_done ? 12'h000 : cnt - 12'h001;
            unique case (state)
                cpci_pkg::U_IDLE: if (!sync2) begin
                    state <= cpci_pkg::U_START;
                    cnt <= 12'(`CPCI_HALF_CYC);
                end
                cpci_pkg::U_START: if (cnt_done) begin
                    // Glitch shorter than half a bit is not a start
                    state <= sync2 ? cpci_pkg::U_IDLE : cpci_pkg::U_DATA;
                    cnt <= 12'(`CPCI_BIT_CYC - 1);
                    bitn <= 3'h0;
                end
                cpci_pkg::U_DATA: if (cnt_done) begin
                    rx_data <= {sync2, rx_data[7:1]};
                    cnt <= 12'(`CPCI_BIT_CYC - 1);
                    bitn <= bitn + 3'h1;
                    if (bitn == 3'h7) begin
                        state <= cpci_pkg::U_STOP;
                    end
                end
                cpci_pkg::U_STOP: if (cnt_done) begin
                    // Framing error drops the character
                    rx_valid <= sync2;
                    state <= cpci_pkg::U_IDLE;
                end
            endcase
        end
    end
endmodule // cpci_uart_rx
`default_nettype wire

// ==== verilog/cpci_uart_tx.sv ====
/*
 * Serial transmitter, 8 data bits, no parity, one stop bit.
 * Assumes tx_data is held while tx_valid is high and tx_ready low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cpci_regs.svh"

module cpci_uart_tx (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Character handshake
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Serial line
    output logic txd
);
    logic [9:0] shreg;
    logic [3:0] bits_left;
    logic [11:0] cnt;
    logic busy;

    assign tx_ready = !busy;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            shreg <= 10'h3FF;
            bits_left <= 4'h0;
            cnt <= 12'h000;
            txd <= 1'b1;
        end else if (!busy) begin
            txd <= 1'b1;
            if (tx_valid) begin
                busy <= 1'b1;
                shreg <= {1'b1, tx_data, 1'b0};
                bits_left <= `CPCI_TX_BITS;
                cnt <= 12'(`CPCI_BIT_CYC - 1);
                txd <= 1'b0;
            end
        end else if (cnt != 12'h000) begin
            cnt <= cnt - 12'h001;
        end else if (bits_left == 4'h0) begin
            busy <= 1'b0;
        end else begin
            shreg <= {1'b1, shreg[9:1]};
            txd <= shreg[1];
            bits_left <= bits_left - 4'h1;
            cnt <= 12'(`CPCI_BIT_CYC - 1);
        end
    end
endmodule // cpci_uart_tx
`default_nettype wire
